// File: bench/msg_host_model.sv
// Purpose: debug host model on the monitor byte link
// Assumes: bytes go whole, one at a time, driven at the falling edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps

// ==========================================
// debug host
module msg_host_model (
	// clock
	input  wire logic       clk,
	// bytes to the device
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	input  wire logic       rx_ready,
	// items from the device
	input  wire logic       tx_valid,
	input  wire logic       tx_break,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [8:0] got_q[$];  // received items, break flag on top
	int         seed = 10; // stall pattern seed

	// idle link at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
	end

	// accept device items with random stalls
	always @(negedge clk)
		tx_ready <= ($random(seed) % 3) != 0;

	// record each accepted item
	always @(posedge clk)
		if (tx_valid && tx_ready)
			got_q.push_back({tx_break, tx_data});

	// offer one byte, hold it until taken, then release
	task automatic send(input logic [7:0] b);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data  = b;
		while (rx_ready !== 1'b1)
			@(negedge clk);
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data  = ~b;
	endtask

	// a security sequence of the first n key bytes, lowest address first
	task automatic send_key(input logic [63:0] k, input int n);
		for (int i = 0; i < n; i++)
			send(k[8*i +: 8]);
	endtask
endmodule // msg_host_model

// File: bench/msg_monitor_gate_tb.sv
// Purpose: self-checking bench of the monitor security gate
// Assumes: host model drives the byte link
// Notes: expectations come from a small integer model
`timescale 1ns/1ps
`include "msg_params.svh"

// ==========================================
// testbench top
module msg_monitor_gate_tb;
	logic                 clk = 1'b0;     // core clock
	logic                 rstn, por;      // resets
	logic                 mon_mode;       // monitor request
	logic                 mass_erase;     // erase pulse
	logic          [63:0] key;            // protected bytes
	logic                 rx_valid, rx_ready, tx_valid, tx_break, tx_ready;
	logic           [7:0] rx_data, tx_data, ram_addr, ram_wdata;
	logic                 cpu_op_valid, cpu_op_ready, ram_we, unlocked;
	msg_pkg::msg_cpu_op_t cpu_op;         // forced cpu op
	logic          [15:0] sp, pc_hi_addr, pc_lo_addr;
	logic           [7:0] flash_rd_data, flash_rd_out;
	logic                 flash_fetch, illegal_addr_rst;
	logic           [8:0] item;           // one host item
	msg_pkg::msg_cpu_op_t got_ops[$];     // ops seen
	int                   err_count = 0, compares = 0, we_cnt = 0, exp_we = 0;
	int                   seed = 10;      // random seed
	bit                   exp_unl;        // model unlock state

	always #5 clk = ~clk;

	msg_monitor_gate #(.DEPTH(16)) uut (.clk(clk), .rstn(rstn), .por(por),
		.mon_mode(mon_mode), .sec_flash_bytes(key), .mass_erase(mass_erase),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_break(tx_break), .tx_data(tx_data), .tx_ready(tx_ready),
		.cpu_op_valid(cpu_op_valid), .cpu_op(cpu_op), .cpu_op_ready(cpu_op_ready),
		.sp(sp), .pc_hi_addr(pc_hi_addr), .pc_lo_addr(pc_lo_addr), .ram_we(ram_we),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .flash_rd_data(flash_rd_data),
		.flash_rd_out(flash_rd_out), .flash_fetch(flash_fetch),
		.illegal_addr_rst(illegal_addr_rst), .unlocked(unlocked));

	msg_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_break(tx_break),
		.tx_data(tx_data), .tx_ready(tx_ready));

	// ==========================================
	// compare tasks and verdict
	task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_op(input msg_pkg::msg_cpu_op_t e, input msg_pkg::msg_cpu_op_t g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value cpu op expected %0d seen %0d", e, g);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================
	// monitors of the cpu side and the status write
	always @(negedge clk)
		cpu_op_ready <= ($random(seed) % 2) != 0;

	always @(posedge clk)
		if (cpu_op_valid && cpu_op_ready)
			got_ops.push_back(cpu_op);

	always @(posedge clk)
		if (ram_we)
		begin
			we_cnt++;
			chk_val("status addr", 16'h0080, {8'h00, ram_addr});
			chk_val("status bit", 16'h0001, {15'h0000, ram_wdata[6]});
		end

	// ==========================================
	// helper tasks
	task automatic get_item();
		repeat (80)
			if (host.got_q.size() == 0)
				@(negedge clk);
		// a missing item reads as a plain byte, so the break check trips
		item = (host.got_q.size() == 0) ? 9'h0XX : host.got_q.pop_front();
	endtask

	task automatic expect_ops(input msg_pkg::msg_cpu_op_t a, input msg_pkg::msg_cpu_op_t b);
		repeat (80)
			if (got_ops.size() < 2)
				@(negedge clk);
		chk_val("op count", 16'h0002, 16'(got_ops.size()));
		if (got_ops.size() == 2)
		begin
			chk_op(a, got_ops.pop_front());
			chk_op(b, got_ops.pop_front());
		end
		got_ops = {};
	endtask

	task automatic reset_dut(input bit with_por);
		rstn = 1'b0;
		por  = with_por;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		por  = 1'b0;
		if (with_por)
			exp_unl = 1'b0;
	endtask

	// break, unlock state, entry ops and status write count at monitor entry
	task automatic entry_done();
		get_item();
		chk_val("break", 16'h0001, {15'h0000, item[8]});
		chk_val("unlocked", {15'h0000, exp_unl}, {15'h0000, unlocked});
		expect_ops(msg_pkg::software_interrupt_op, msg_pkg::push_index_high_op);
		chk_val("status writes", 16'(exp_we), 16'(we_cnt));
	endtask

	// flash read gating and fetch guard
	task automatic flash_probe();
		flash_rd_data = 8'($random(seed));
		flash_fetch   = 1'b1;
		@(negedge clk);
		flash_fetch = 1'b0;
		chk_val("flash read", {8'h00, (exp_unl ? flash_rd_data : `MSG_INVALID)},
			{8'h00, flash_rd_out});
		chk_val("illegal reset", {15'h0000, !exp_unl}, {15'h0000, illegal_addr_rst});
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		rstn = 1'b0; por = 1'b1; mon_mode = 1'b0; mass_erase = 1'b0;
		key = {$random(seed), $random(seed)};
		key[7] = 1'b0;
		sp = 16'($random(seed)); flash_rd_data = 8'h00; flash_fetch = 1'b0;
		reset_dut(1'b1);
		// fill the queue while the sequencer waits: key then eight fillers
		host.send_key({key}, 8);
		host.send_key(64'h0, 8);
		chk_val("queue full", 16'h0000, {15'h0000, rx_ready});
		mon_mode = 1'b1;
		exp_unl = 1'b1;
		exp_we++;
		entry_done();
		chk_val("queue drained", 16'h0001, {15'h0000, rx_ready});
		flash_probe();
		host.send(`MSG_RDSP_OPC);
		get_item();
		chk_val("stack ptr", {7'h00, 1'b0, 8'(sp + 16'h0001)}, {7'h00, item});
		chk_val("pc high addr", sp + 16'h0005, pc_hi_addr);
		chk_val("pc low addr", sp + 16'h0006, pc_lo_addr);
		// host prepares its own context: a new stack frame before run
		sp = 16'($random(seed));
		@(negedge clk);
		chk_val("new pc high addr", sp + 16'h0005, pc_hi_addr);
		chk_val("new pc low addr", sp + 16'h0006, pc_lo_addr);
		host.send(8'h28);
		expect_ops(msg_pkg::pop_index_high_op, msg_pkg::return_from_interrupt_op);
		// plain reset keeps the unlock and skips the key
		reset_dut(1'b0);
		entry_done();
		// power-on with a key wrong in one random bit
		reset_dut(1'b1);
		// the flipped bit stays inside the first seven bytes sent
		host.send_key(key ^ (64'h1 << ($unsigned($random(seed)) % 56)), 7);
		repeat (8) @(negedge clk);
		chk_val("early item", 16'h0000, 16'(host.got_q.size()));
		host.send_key(key >> 56, 1);
		entry_done();
		flash_probe();
		// power-on, erase, then the blank key opens
		reset_dut(1'b1);
		mass_erase = 1'b1;
		@(negedge clk);
		mass_erase = 1'b0;
		host.send_key({8{8'hFF}}, 8);
		exp_unl = 1'b1;
		exp_we++;
		entry_done();
		finish_test();
	end

	// watchdog against a hung handshake
	initial
	begin
		#200us;
		err_count++;
		finish_test();
	end
endmodule // msg_monitor_gate_tb

// File: include/msg_params.svh
// Purpose: constants of the monitor security gate
// Assumes: byte-wide monitor link, 16-bit addresses
// Notes: definitions only
`ifndef MSG_PARAMS_SVH
`define MSG_PARAMS_SVH

// ==========================================
// security locations
`define MSG_SEC_BASE    16'hFFF6
`define MSG_SEC_LAST    16'hFFFD
`define MSG_SEC_COUNT   8
`define MSG_ERASED      8'hFF

// ==========================================
// monitor commands
`define MSG_RUN_OPC     8'h28
`define MSG_RDSP_OPC    8'h0C

// ==========================================
// stack offsets
`define MSG_SP_INC      16'h0001
`define MSG_PC_HI_OFS   16'h0005
`define MSG_PC_LO_OFS   16'h0006

// ==========================================
// unlock status byte in ram
`define MSG_STAT_ADDR   8'h80
`define MSG_STAT_BIT    6
`define MSG_STAT_VAL    8'h40

// ==========================================
// buffering and gating
`define MSG_FIFO_DEPTH  16
`define MSG_INVALID     8'h00

`endif

// File: include/msg_pkg.sv
// Purpose: types of the monitor security gate
// Assumes: used with msg_params.svh
// Notes: types only
package msg_pkg;

	// ==========================================
	// sequencer states
	typedef enum logic [3:0] {
		st_idle,
		st_collect,
		st_break,
		st_sw_int,
		st_push_hi,
		st_serve,
		st_send_sp,
		st_pop_hi,
		st_return,
		st_running
	} msg_state_t;

	// ==========================================
	// cpu operations forced by the monitor
	typedef enum logic [1:0] {
		software_interrupt_op,
		push_index_high_op,
		pop_index_high_op,
		return_from_interrupt_op
	} msg_cpu_op_t;

endpackage

// File: verilog/msg_monitor_gate.sv
// Purpose: monitor entry, security compare and run/read-sp service
// Assumes: bytes from the serial receiver arrive on clk, por is a pulse
// Notes: fifo and gate share this file
`timescale 1ns/1ps
`include "msg_params.svh"

// ==========================================
// byte fifo
module msg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `MSG_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // storage
	logic [AW:0]      wr_ptr;       // write pointer with wrap bit
	logic [AW:0]      rd_ptr;       // read pointer with wrap bit
	logic             push;         // word accepted
	logic             pop;          // word drained

	// full when pointers differ only in wrap bit
	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	// pointers
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // msg_fifo

// ==========================================
// monitor security gate
// How it works
// R1: run command pops index high, then returns
// R2: entry takes software interrupt, pushes index high
// R3: host may rewrite stacked registers before run
// R4: read stack pointer returns pointer plus one; code sends only the low byte of sp+1
// R5: stacked pc high at sp+5, low sp+6
// R6: after power-on, eight security bytes are collected
// R7: all eight match unlocks flash read and execute
// R8: unlock survives every reset except power-on
// R9: locked flash reads return an invalid value
// R10: locked flash fetch raises illegal-address reset
// R11: break sent only after all eight bytes; code sends it at once when need_sec is clear
// R12: match sets bit 6 of ram byte 80h
// R13: host power-cycles before retrying failed security
// R14: mass erase makes all security bytes FFh
// R15: user should program all security locations
// R16: bytes compared in order, lowest address first
module msg_monitor_gate #(
	parameter int DEPTH = `MSG_FIFO_DEPTH
) (
	// clock and resets
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        por,
	// mode and flash contents
	input  wire logic        mon_mode,
	input  wire logic [63:0] sec_flash_bytes,
	input  wire logic        mass_erase,
	// received monitor bytes
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	// transmit to host
	output logic             tx_valid,
	output logic             tx_break,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	// forced cpu operations
	output logic             cpu_op_valid,
	output msg_pkg::msg_cpu_op_t cpu_op,
	input  wire logic        cpu_op_ready,
	input  wire logic [15:0] sp,
	output logic [15:0]      pc_hi_addr,
	output logic [15:0]      pc_lo_addr,
	// unlock status write
	output logic             ram_we,
	output logic [7:0]       ram_addr,
	output logic [7:0]       ram_wdata,
	// flash gating
	input  wire logic [7:0]  flash_rd_data,
	output logic [7:0]       flash_rd_out,
	input  wire logic        flash_fetch,
	output logic             illegal_addr_rst,
	output logic             unlocked
);
	msg_pkg::msg_state_t state;       // sequencer state
	msg_pkg::msg_state_t next_state;  // next sequencer state
	logic [7:0]  shadow [`MSG_SEC_COUNT];  // security byte copy
	logic [2:0]  sec_idx;             // next byte to compare
	logic        sec_fail;            // mismatch seen so far
	logic        need_sec;            // power-on entry pending
	logic        sec_done;            // eight bytes collected
	logic        f_valid;             // fifo has a byte
	logic [7:0]  f_data;              // fifo head byte
	logic        f_ready;             // sequencer takes a byte
	logic        take;                // byte taken this cycle
	logic        last_byte;           // eighth security byte
	logic        byte_ok;             // byte matches location
	logic        op_done;             // cpu op accepted
	logic        tx_done;             // transmit accepted

	// incoming bytes are buffered; back-pressure is rx_ready
	msg_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (rx_valid),
		.in_data   (rx_data),
		.in_ready  (rx_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (f_ready)
	);

	// handshake terms
	assign f_ready   = (state == msg_pkg::st_collect) || (state == msg_pkg::st_serve);
	assign take      = f_valid && f_ready;
	assign last_byte = sec_idx == 3'(`MSG_SEC_COUNT - 1);
	assign byte_ok   = f_data == shadow[sec_idx];  // R16
	assign op_done   = cpu_op_valid && cpu_op_ready;
	assign tx_done   = tx_valid && tx_ready;

	// shadow of the protected bytes, one entry per location
	generate
		for (genvar i = 0; i < `MSG_SEC_COUNT; i++)
		begin : g_shadow
			always_ff @(posedge clk)
			begin
				if (mass_erase)
					shadow[i] <= `MSG_ERASED;  // R14
				else if (por)
					shadow[i] <= sec_flash_bytes[8*i +: 8];
			end
		end
	endgenerate

	// power-on entry flag, kept through ordinary resets
	always_ff @(posedge clk)
	begin
		if (por)
			need_sec <= 1'b1;  // R6
		else if (take && state == msg_pkg::st_collect && last_byte)
			need_sec <= 1'b0;
	end

	// unlock flag, cleared by power-on only
	always_ff @(posedge clk)
	begin
		if (por)
			unlocked <= 1'b0;  // R8
		else if (take && state == msg_pkg::st_collect && last_byte)
			unlocked <= !sec_fail && byte_ok;  // R7
	end

	// security byte walk
	always_ff @(posedge clk)
	begin
		if (!rstn || por)
		begin
			sec_idx  <= '0;
			sec_fail <= 1'b0;
			sec_done <= 1'b0;
		end
		else if (take && state == msg_pkg::st_collect)
		begin
			sec_idx  <= sec_idx + 3'd1;
			sec_fail <= sec_fail || !byte_ok;  // R16
			sec_done <= last_byte;
		end
	end

	// next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			msg_pkg::st_idle:
				if (mon_mode)
					next_state = need_sec ? msg_pkg::st_collect : msg_pkg::st_break;
			msg_pkg::st_collect:
				if (take && last_byte)
					next_state = msg_pkg::st_break;  // R11
			msg_pkg::st_break:
				if (tx_done)
					next_state = msg_pkg::st_sw_int;
			msg_pkg::st_sw_int:
				if (op_done)
					next_state = msg_pkg::st_push_hi;  // R2
			msg_pkg::st_push_hi:
				if (op_done)
					next_state = msg_pkg::st_serve;
			msg_pkg::st_serve:
				if (take && f_data == `MSG_RUN_OPC)
					next_state = msg_pkg::st_pop_hi;  // R1
				else if (take && f_data == `MSG_RDSP_OPC)
					next_state = msg_pkg::st_send_sp;
			msg_pkg::st_send_sp:
				if (tx_done)
					next_state = msg_pkg::st_serve;
			msg_pkg::st_pop_hi:
				if (op_done)
					next_state = msg_pkg::st_return;  // R1
			msg_pkg::st_return:
				if (op_done)
					next_state = msg_pkg::st_running;
			msg_pkg::st_running:
				next_state = msg_pkg::st_running;
			default:
				next_state = msg_pkg::st_idle;
		endcase
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!rstn || por)
			state <= msg_pkg::st_idle;
		else
			state <= next_state;
	end

	// forced cpu operations follow the state
	always_comb
	begin
		cpu_op_valid = 1'b1;
		cpu_op       = msg_pkg::software_interrupt_op;
		unique case (state)
			msg_pkg::st_sw_int:  cpu_op = msg_pkg::software_interrupt_op;
			msg_pkg::st_push_hi: cpu_op = msg_pkg::push_index_high_op;
			msg_pkg::st_pop_hi:  cpu_op = msg_pkg::pop_index_high_op;
			msg_pkg::st_return:  cpu_op = msg_pkg::return_from_interrupt_op;
			default:          cpu_op_valid = 1'b0;
		endcase
	end

	// transmit: break at entry, after collection when one runs, sp+1 on request
	always_ff @(posedge clk)
	begin
		if (!rstn || por)
		begin
			tx_valid <= 1'b0;
			tx_break <= 1'b0;
			tx_data  <= 8'h00;
		end
		else if (tx_done)
		begin
			tx_valid <= 1'b0;
			tx_break <= 1'b0;
		end
		else if (state == msg_pkg::st_idle && next_state == msg_pkg::st_break)
		begin
			tx_valid <= 1'b1;
			tx_break <= 1'b1;
		end
		else if (state == msg_pkg::st_collect && next_state == msg_pkg::st_break)
		begin
			tx_valid <= 1'b1;
			tx_break <= 1'b1;  // R11
		end
		else if (state == msg_pkg::st_serve && next_state == msg_pkg::st_send_sp)
		begin
			tx_valid <= 1'b1;
			tx_data  <= 8'((sp + `MSG_SP_INC) & 16'h00FF);  // R4
		end
		else if (state == msg_pkg::st_send_sp && !tx_valid)
			tx_valid <= 1'b1;
	end

	// stacked program counter addresses
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pc_hi_addr <= 16'h0000;
			pc_lo_addr <= 16'h0000;
		end
		else
		begin
			pc_hi_addr <= sp + `MSG_PC_HI_OFS;  // R5
			pc_lo_addr <= sp + `MSG_PC_LO_OFS;  // R5
		end
	end

	// unlock status write into ram
	always_ff @(posedge clk)
	begin
		if (!rstn || por)
			ram_we <= 1'b0;
		else
			ram_we <= take && state == msg_pkg::st_collect && last_byte
				&& !sec_fail && byte_ok;  // R12
	end
	assign ram_addr  = `MSG_STAT_ADDR;
	assign ram_wdata = `MSG_STAT_VAL;

	// flash read gating and fetch policing
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			flash_rd_out     <= `MSG_INVALID;
			illegal_addr_rst <= 1'b0;
		end
		else
		begin
			flash_rd_out     <= unlocked ? flash_rd_data : `MSG_INVALID;  // R9
			illegal_addr_rst <= flash_fetch && !unlocked;  // R10
		end
	end

	// ==========================================
	// assertions
	a_run_pops_first: assert property (@(posedge clk) disable iff (!rstn || por) // R1
		state == msg_pkg::st_serve && take && f_data == `MSG_RUN_OPC
		|=> cpu_op_valid && cpu_op == msg_pkg::pop_index_high_op)
		else $error("run did not start with pop");

	a_rti_after_pop: assert property (@(posedge clk) disable iff (!rstn || por) // R1
		op_done && cpu_op == msg_pkg::pop_index_high_op
		|=> cpu_op == msg_pkg::return_from_interrupt_op)
		else $error("return not after pop");

	a_swi_then_push: assert property (@(posedge clk) disable iff (!rstn || por) // R2
		op_done && cpu_op == msg_pkg::software_interrupt_op
		|=> cpu_op_valid && cpu_op == msg_pkg::push_index_high_op)
		else $error("push not after interrupt");

	a_read_sp_plus: assert property (@(posedge clk) disable iff (!rstn || por) // R4
		state == msg_pkg::st_serve && take && f_data == `MSG_RDSP_OPC
		|=> tx_valid && tx_data == 8'(($past(sp) + 16'h0001) & 16'h00FF))
		else $error("read sp not plus one");

	a_pc_offsets: assert property (@(posedge clk) disable iff (!rstn) // R5
		1'b1 |=> pc_hi_addr == $past(sp) + 16'h0005
		&& pc_lo_addr == $past(sp) + 16'h0006)
		else $error("stacked pc address wrong");

	a_por_locks: assert property (@(posedge clk) // R8
		por |=> !unlocked)
		else $error("power-on left unlock set");

	a_locked_read: assert property (@(posedge clk) disable iff (!rstn) // R9
		!unlocked |=> flash_rd_out == 8'h00)
		else $error("locked read leaked data");

	a_locked_fetch: assert property (@(posedge clk) disable iff (!rstn) // R10
		flash_fetch && !unlocked |=> illegal_addr_rst)
		else $error("locked fetch not reset");

	a_break_after_eight: assert property (@(posedge clk) disable iff (!rstn || por) // R11
		$rose(tx_break) |-> sec_done || !need_sec)
		else $error("break before eight bytes");

	a_status_on_match: assert property (@(posedge clk) disable iff (!rstn || por) // R12
		ram_we |-> unlocked && ram_addr == 8'h80 && ram_wdata[6])
		else $error("status write without unlock");

	a_erase_blank: assert property (@(posedge clk) // R14
		mass_erase |=> shadow[0] == 8'hFF && shadow[7] == 8'hFF)
		else $error("erase left security bytes");
endmodule // msg_monitor_gate
